// *** core/signal_modulator.sv ***
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
//
// Overview of operation
// - source code picks software bit, input pin, serial, uart or pwm outputs.
// - source disable bit blocks the selected source's own output pin.
// - source disable bit is cleared only by power-on reset, kept otherwise.
// - source select bits survive other resets; power-on reset loads code 1111; software programs them before use.
// - high carrier code picks ground, two pins, reference clock or pwm outputs.
// - low carrier code uses the same mapping as the high carrier code.
// - high carrier disable bit blocks the selected carrier's own output pin.
// - low carrier disable bit blocks its pin; cleared at power-on reset.
// - high carrier polarity bit inverts the high carrier.
// - low carrier polarity bit inverts the low carrier.
// - with high sync, switch to low waits for high carrier falling edge.
// - with low sync, switch to high waits for low carrier falling edge.
// - unimplemented register bits read as zero.
// - output is the carriers and modulating signal combined by and-or, to output pin.
// - enable bit gates routing and mixing, not the pin disables; disabled means no modulated output.
// - output polarity bit inverts the final modulated output.
module signal_modulator (
    input  wire logic                        mclk_i,                 // module clock
    input  wire logic                        rst_b_i,                // power-on reset
    input  wire logic                        sys_reset_i,            // other resets, sync
    input  wire logic [dsm_pkg::ADDR_W-1:0]  addr_i,                 // register address
    input  wire logic [dsm_pkg::DATA_W-1:0]  wdata_i,                // write data
    input  wire logic                        wr_i,                   // write strobe
    input  wire logic                        rd_i,                   // read strobe
    output logic      [dsm_pkg::DATA_W-1:0]  rdata_o,                // read data, next cycle
    input  wire logic                        modulation_input_pin_i, // external modulator
    input  wire logic                        serial_out_one_i,       // serial peripheral 1
    input  wire logic                        serial_out_two_i,       // serial peripheral 2
    input  wire logic [dsm_pkg::N_UART-1:0]  uart_tx_i,              // uart transmit lines
    input  wire logic [dsm_pkg::N_PWM-1:0]   pwm_out_i,              // compare/pwm outputs
    input  wire logic                        carrier_input_pin_one_i,// carrier pin 1
    input  wire logic                        carrier_input_pin_two_i,// carrier pin 2
    input  wire logic                        reference_clock_output_i,// reference clock
    output logic                             modulated_output_pin_o, // modulated result
    output logic      [dsm_pkg::N_SEL-1:0]   source_pin_off_o,       // per source code
    output logic      [dsm_pkg::N_SEL-1:0]   high_pin_off_o,         // per carrier code
    output logic      [dsm_pkg::N_SEL-1:0]   low_pin_off_o           // per carrier code
);
    import dsm_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] control;
        logic              source_pin_output_disable;
        logic [SEL_W-1:0]  source_select_code;
        logic [DATA_W-1:0] carrier;
        carrier_state_e    route;
        logic              mod_out;
        logic [N_SEL-1:0]  src_off;
        logic [N_SEL-1:0]  high_off;
        logic [N_SEL-1:0]  low_off;
        logic [DATA_W-1:0] rdata;
    } mod_s;

    mod_s mods;
    mod_s next_mods;

    // decoded register fields
    logic             modulator_enable;
    logic             output_invert;
    logic             manual_modulation_bit;
    logic             high_carrier_pin_disable;
    logic             high_carrier_invert;
    logic             high_carrier_sync_enable;
    logic [SEL_W-1:0] high_carrier_select_code;
    logic             low_carrier_pin_disable;
    logic             low_carrier_invert;
    logic             low_carrier_sync_enable;
    logic [SEL_W-1:0] low_carrier_select_code;

    // candidate vectors indexed by select code
    logic [N_SEL-1:0] source_cands;
    logic [N_SEL-1:0] carrier_cands;

    // conditioned carriers
    logic high_carrier;
    logic high_fall;
    logic low_carrier;
    logic low_fall;

    // pin disable decode per code
    logic [N_SEL-1:0] src_off_dec;
    logic [N_SEL-1:0] high_off_dec;
    logic [N_SEL-1:0] low_off_dec;

    logic modulating;

    assign modulator_enable         = mods.control[CTL_ENABLE_BIT];
    assign output_invert            = mods.control[CTL_INVERT_BIT];
    assign manual_modulation_bit    = mods.control[CTL_MANUAL_BIT];
    assign high_carrier_pin_disable = mods.carrier[CAR_H_DISABLE_BIT];
    assign high_carrier_invert      = mods.carrier[CAR_H_INVERT_BIT];
    assign high_carrier_sync_enable = mods.carrier[CAR_H_SYNC_BIT];
    assign high_carrier_select_code = mods.carrier[CAR_H_SEL_LSB +: SEL_W];
    assign low_carrier_pin_disable  = mods.carrier[CAR_L_DISABLE_BIT];
    assign low_carrier_invert       = mods.carrier[CAR_L_INVERT_BIT];
    assign low_carrier_sync_enable  = mods.carrier[CAR_L_SYNC_BIT];
    assign low_carrier_select_code  = mods.carrier[CAR_L_SEL_LSB +: SEL_W];

    // code 1111 has no signal behind it and reads as ground
    assign source_cands = {
        1'b0,
        pwm_out_i,
        uart_tx_i,
        serial_out_two_i,
        serial_out_one_i,
        modulation_input_pin_i,
        manual_modulation_bit
    };

    // codes above the last pwm output are reserved and read as ground
    assign carrier_cands = {
        5'h00,
        pwm_out_i,
        reference_clock_output_i,
        carrier_input_pin_two_i,
        carrier_input_pin_one_i,
        1'b0
    };

    assign modulating = modulator_enable & source_cands[mods.source_select_code];

    carrier_conditioner #(
        .N_CAND (N_SEL)
    ) u_high (
        .mclk_i    (mclk_i),
        .rst_b_i   (rst_b_i),
        .clear_i   (sys_reset_i),
        .sel_i     (high_carrier_select_code),
        .cand_i    (carrier_cands),
        .invert_i  (high_carrier_invert),
        .carrier_o (high_carrier),
        .fall_o    (high_fall)
    );

    // same mapping as the high side, one shared candidate vector
    carrier_conditioner #(
        .N_CAND (N_SEL)
    ) u_low (
        .mclk_i    (mclk_i),
        .rst_b_i   (rst_b_i),
        .clear_i   (sys_reset_i),
        .sel_i     (low_carrier_select_code),
        .cand_i    (carrier_cands),
        .invert_i  (low_carrier_invert),
        .carrier_o (low_carrier),
        .fall_o    (low_fall)
    );

    for (genvar i = 0; i < N_SEL; i++) begin : g_pin_off
        localparam logic [SEL_W-1:0] CODE = SEL_W'(i);
        assign src_off_dec[i]  = mods.source_pin_output_disable
                                 & (mods.source_select_code == CODE);
        assign high_off_dec[i] = high_carrier_pin_disable
                                 & (high_carrier_select_code == CODE);
        assign low_off_dec[i]  = low_carrier_pin_disable
                                 & (low_carrier_select_code == CODE);
    end

    always_comb begin
        next_mods = mods;

        // register writes; unmapped addresses are ignored
        if (wr_i) begin
            unique case (addr_i)
                ADDR_CONTROL: begin
                    next_mods.control = wdata_i & CTL_MASK;
                end
                ADDR_SOURCE: begin
                    next_mods.source_pin_output_disable = wdata_i[SRC_DISABLE_BIT];
                    next_mods.source_select_code = wdata_i[SRC_SEL_LSB +: SEL_W];
                end
                ADDR_CARRIER: begin
                    next_mods.carrier = wdata_i & CAR_MASK;
                end
                default: begin
                end
            endcase
        end

        // register reads, answer stands one cycle after the strobe
        next_mods.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_CONTROL: begin
                    next_mods.rdata = mods.control & CTL_MASK;
                end
                ADDR_SOURCE: begin
                    next_mods.rdata[SRC_DISABLE_BIT] = mods.source_pin_output_disable;
                    next_mods.rdata[SRC_SEL_LSB +: SEL_W] = mods.source_select_code;
                end
                ADDR_CARRIER: begin
                    next_mods.rdata = mods.carrier & CAR_MASK;
                end
                default: begin
                    next_mods.rdata = '0;
                end
            endcase
        end

        // carrier routing with optional falling-edge synchronisation
        if (!modulator_enable) begin
            next_mods.route = CAR_LOW;
        end else begin
            unique case (mods.route)
                CAR_HIGH: begin
                    // an early switch could cut a high pulse short
                    if (!modulating && (!high_carrier_sync_enable || high_fall)) begin
                        next_mods.route = CAR_LOW;
                    end
                end
                CAR_LOW: begin
                    if (modulating && (!low_carrier_sync_enable || low_fall)) begin
                        next_mods.route = CAR_HIGH;
                    end
                end
            endcase
        end

        // and-or mix: route high gates the high carrier, route low the low one
        if (!modulator_enable) begin
            next_mods.mod_out = 1'b0;
        end else if (next_mods.route == CAR_HIGH) begin
            next_mods.mod_out = high_carrier ^ output_invert;
        end else begin
            next_mods.mod_out = low_carrier ^ output_invert;
        end

        // pin disables follow the selection one cycle later
        next_mods.src_off  = src_off_dec;
        next_mods.high_off = high_off_dec;
        next_mods.low_off  = low_off_dec;

        // other resets clear control and carrier but leave the source register
        if (sys_reset_i) begin
            next_mods.control = CTL_POR;
            next_mods.carrier = CAR_POR;
            next_mods.route   = CAR_LOW;
            next_mods.mod_out = 1'b0;
            next_mods.source_pin_output_disable = mods.source_pin_output_disable;
            next_mods.source_select_code = mods.source_select_code;
        end
    end

    // source select has no defined power-on value; it loads the ground code
    // so an unprogrammed block stays quiet until software sets it
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mods.control  <= CTL_POR;
            mods.source_pin_output_disable <= SRC_DIS_POR;
            mods.source_select_code <= SRC_SEL_POR;
            mods.carrier  <= CAR_POR;
            mods.route    <= CAR_LOW;
            mods.mod_out  <= 1'b0;
            mods.src_off  <= '0;
            mods.high_off <= '0;
            mods.low_off  <= '0;
            mods.rdata    <= '0;
        end else begin
            mods <= next_mods;
        end
    end

    assign rdata_o                = mods.rdata;
    assign modulated_output_pin_o = mods.mod_out;
    assign source_pin_off_o       = mods.src_off;
    assign high_pin_off_o         = mods.high_off;
    assign low_pin_off_o          = mods.low_off;

endmodule

// *** core/dsm_pkg.sv ***
package dsm_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned N_SEL  = 16;
    localparam int unsigned N_UART = 4;
    localparam int unsigned N_PWM  = 7;

    // word addresses on the register port
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_SOURCE  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CARRIER = 4'h2;

    // modulator_control fields
    localparam int unsigned CTL_ENABLE_BIT = 15;
    localparam int unsigned CTL_INVERT_BIT = 4;
    localparam int unsigned CTL_MANUAL_BIT = 0;

    // modulation_source_select fields
    localparam int unsigned SRC_DISABLE_BIT = 7;
    localparam int unsigned SRC_SEL_LSB     = 0;

    // carrier_select_control fields
    localparam int unsigned CAR_H_DISABLE_BIT = 15;
    localparam int unsigned CAR_H_INVERT_BIT  = 14;
    localparam int unsigned CAR_H_SYNC_BIT    = 13;
    localparam int unsigned CAR_H_SEL_LSB     = 8;
    localparam int unsigned CAR_L_DISABLE_BIT = 7;
    localparam int unsigned CAR_L_INVERT_BIT  = 6;
    localparam int unsigned CAR_L_SYNC_BIT    = 5;
    localparam int unsigned CAR_L_SEL_LSB     = 0;

    // implemented bits of each register
    localparam logic [DATA_W-1:0] CTL_MASK = 16'h8011;
    localparam logic [DATA_W-1:0] SRC_MASK = 16'h008f;
    localparam logic [DATA_W-1:0] CAR_MASK = 16'hefef;

    // power-on values
    localparam logic [DATA_W-1:0] CTL_POR     = 16'h0000;
    localparam logic              SRC_DIS_POR = 1'b0;
    localparam logic [SEL_W-1:0]  SRC_SEL_POR = 4'hf;
    localparam logic [DATA_W-1:0] CAR_POR     = 16'h0000;

    // source select codes
    localparam logic [SEL_W-1:0] SRC_MANUAL     = 4'h0;
    localparam logic [SEL_W-1:0] SRC_PIN        = 4'h1;
    localparam logic [SEL_W-1:0] SRC_SERIAL_ONE = 4'h2;
    localparam logic [SEL_W-1:0] SRC_SERIAL_TWO = 4'h3;
    localparam logic [SEL_W-1:0] SRC_UART_FIRST = 4'h4;
    localparam logic [SEL_W-1:0] SRC_PWM_FIRST  = 4'h8;
    localparam logic [SEL_W-1:0] SRC_UNIMPL     = 4'hf;

    // carrier select codes, shared by high and low carrier
    localparam logic [SEL_W-1:0] CAR_VSS       = 4'h0;
    localparam logic [SEL_W-1:0] CAR_PIN_ONE   = 4'h1;
    localparam logic [SEL_W-1:0] CAR_PIN_TWO   = 4'h2;
    localparam logic [SEL_W-1:0] CAR_REFCLK    = 4'h3;
    localparam logic [SEL_W-1:0] CAR_PWM_FIRST = 4'h4;
    localparam logic [SEL_W-1:0] CAR_LAST      = 4'ha;

    typedef enum logic [0:0] {
        CAR_LOW,
        CAR_HIGH
    } carrier_state_e;

endpackage

// *** core/carrier_conditioner.sv ***
`timescale 1ns/1ns
module carrier_conditioner #(
    parameter int unsigned N_CAND = dsm_pkg::N_SEL
) (
    input  wire logic                     mclk_i,    // module clock
    input  wire logic                     rst_b_i,   // power-on reset, active low
    input  wire logic                     clear_i,   // synchronous clear of edge history
    input  wire logic [dsm_pkg::SEL_W-1:0] sel_i,    // select code
    input  wire logic [N_CAND-1:0]        cand_i,    // candidate signals by code
    input  wire logic                     invert_i,  // polarity select
    output logic                          carrier_o, // conditioned carrier
    output logic                          fall_o     // conditioned carrier fell
);
    import dsm_pkg::*;

    typedef struct packed {
        logic last;
    } cond_s;

    cond_s cond;
    cond_s next_cond;
    logic  picked;

    if (N_CAND < 1 || N_CAND > N_SEL) begin : g_check
        $error("carrier_conditioner: N_CAND out of range");
    end

    always_comb begin
        picked = 1'b0;
        // codes without a candidate read as ground, never a floating value
        if (32'(sel_i) < N_CAND) begin
            picked = cand_i[sel_i];
        end
        carrier_o = picked ^ invert_i;
        fall_o    = cond.last & ~carrier_o;
        next_cond = cond;
        next_cond.last = clear_i ? 1'b0 : carrier_o;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cond <= '0;
        end else begin
            cond <= next_cond;
        end
    end

endmodule

// *** sim/dsm_periph_model.sv ***
`timescale 1ns/1ns
module dsm_periph_model (
    input  wire logic        mclk_i,    // clock
    input  wire logic        rst_b_i,   // power-on reset
    input  wire logic [16:0] lines_i,   // wanted levels
    output logic             pin_o,     // modulation pin
    output logic             sdo_one_o, // serial 1
    output logic             sdo_two_o, // serial 2
    output logic [3:0]       uart_o,    // uart lines
    output logic [6:0]       pwm_o,     // pwm lines
    output logic             cin_one_o, // carrier pin 1
    output logic             cin_two_o, // carrier pin 2
    output logic             refclk_o   // reference clock
);
    // peripherals move just after the edge, as synchronous logic would
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {refclk_o, cin_two_o, cin_one_o, pwm_o, uart_o, sdo_two_o, sdo_one_o, pin_o} <= '0;
        end else begin
            {refclk_o, cin_two_o, cin_one_o, pwm_o, uart_o, sdo_two_o, sdo_one_o, pin_o} <= lines_i;
        end
    end
endmodule

// *** sim/signal_modulator_monitor.sv ***
`timescale 1ns/1ns
module signal_modulator_monitor (
    input wire logic                       mclk_i,                 // clock
    input wire logic                       rst_b_i,                // power-on reset
    input wire logic                       sys_reset_i,            // other resets
    input wire logic [dsm_pkg::ADDR_W-1:0] addr_i,                 // address
    input wire logic [dsm_pkg::DATA_W-1:0] wdata_i,                // write data
    input wire logic                       wr_i,                   // write strobe
    input wire logic                       rd_i,                   // read strobe
    input wire logic [dsm_pkg::DATA_W-1:0] rdata_o,                // read data
    input wire logic                       modulated_output_pin_o, // result
    input wire logic [dsm_pkg::N_SEL-1:0]  source_pin_off_o,       // source pin off
    input wire logic [dsm_pkg::N_SEL-1:0]  high_pin_off_o,         // high pin off
    input wire logic [dsm_pkg::N_SEL-1:0]  low_pin_off_o           // low pin off
);
    import dsm_pkg::*;
    logic [DATA_W-1:0] ctl, src, car, src_d, car_d, rd_model;
    logic              quiet_ok;

    function automatic logic quiet(input logic [SEL_W-1:0] c);
        return (c == CAR_VSS) || (c > CAR_LAST);
    endfunction
    function automatic logic [N_SEL-1:0] pin_off(input logic dis, input logic [SEL_W-1:0] c);
        return dis ? (N_SEL'(1) << c) : '0;
    endfunction

    // shadow of the registers; source word ignores the soft reset
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl <= CTL_POR;
            src <= {8'h00, SRC_DIS_POR, 3'h0, SRC_SEL_POR};
            car <= CAR_POR;
            src_d <= {8'h00, SRC_DIS_POR, 3'h0, SRC_SEL_POR};
            car_d <= CAR_POR;
        end else begin
            src_d <= src;
            car_d <= car;
            // soft reset blocks every register write in its cycle, source too
            if (wr_i && addr_i == ADDR_SOURCE && !sys_reset_i) src <= wdata_i & SRC_MASK;
            if (sys_reset_i) begin
                ctl <= '0;
                car <= '0;
            end else if (wr_i) begin
                if (addr_i == ADDR_CONTROL) ctl <= wdata_i & CTL_MASK;
                if (addr_i == ADDR_CARRIER) car <= wdata_i & CAR_MASK;
            end
        end
    end
    always_comb begin
        case (addr_i)
            ADDR_CONTROL: rd_model = ctl;
            ADDR_SOURCE:  rd_model = src;
            ADDR_CARRIER: rd_model = car;
            default:      rd_model = '0;
        endcase
    end
    assign quiet_ok = ctl[15] && quiet(car[11:8]) && quiet(car[3:0]) && !car[14] && !car[6];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    AST_RD_DATA: assert property ($past(rd_i) |-> rdata_o == $past(rd_model))
        else $error("read data differs from register");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == '0)
        else $error("read data outside read slot");
    AST_SRC_PIN_OFF: assert property (src_d[3:0] != SRC_UNIMPL |->
        source_pin_off_o == pin_off(src_d[7], src_d[3:0])) else $error("source pin off wrong");
    AST_HIGH_PIN_OFF: assert property (!quiet(car_d[11:8]) |->
        high_pin_off_o == pin_off(car_d[15], car_d[11:8])) else $error("high pin off wrong");
    AST_LOW_PIN_OFF: assert property (!quiet(car_d[3:0]) |->
        low_pin_off_o == pin_off(car_d[7], car_d[3:0])) else $error("low pin off wrong");
    AST_DISABLED_QUIET: assert property ((!ctl[15])[*3] |=> !modulated_output_pin_o)
        else $error("output active while disabled");
    AST_CONST_OUT: assert property ((quiet_ok && !wr_i)[*3] |=>
        modulated_output_pin_o == ctl[4]) else $error("constant carriers give wrong output");
    AST_SYS_CLEAR: assert property (sys_reset_i |=> !modulated_output_pin_o)
        else $error("output not cleared by soft reset");

    cover property (rd_i && addr_i == ADDR_SOURCE);
    cover property (sys_reset_i && ctl[15]);
    cover property ($rose(modulated_output_pin_o));
endmodule

bind signal_modulator signal_modulator_monitor i_signal_modulator_monitor (
    .mclk_i, .rst_b_i, .sys_reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .modulated_output_pin_o, .source_pin_off_o, .high_pin_off_o, .low_pin_off_o
);

// *** sim/signal_modulator_tb.sv ***
`timescale 1ns/1ns
module signal_modulator_tb;
    import dsm_pkg::*;
    logic              mclk = 1'b0, rst_b = 1'b0, sys_reset = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, src_off, hi_off, lo_off;
    logic [16:0]       lines = '0, onehot;
    logic              mod_out, min_pin, serial_out_one, serial_out_two, cin1, cin2, refclk;
    logic [3:0]        uart;
    logic [6:0]        pwm;
    logic [15:0]       car_t [5] = '{16'h4000, 16'h4000, 16'h0040, 16'h0000, 16'h0000};
    logic [15:0]       ctl_t [5] = '{16'h8001, 16'h8000, 16'h8000, 16'h8010, 16'h0010};
    logic              exp_t [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0]       mask_t [3] = '{CTL_MASK, SRC_MASK, CAR_MASK};
    logic [15:0]       sync_t [2] = '{16'h2102, 16'h0221};
    int                miscompares = 0, total_checks = 0, cycles = 0, c, v, h;

    dsm_periph_model i_dsm_periph_model (.mclk_i(mclk), .rst_b_i(rst_b), .lines_i(lines),
        .pin_o(min_pin), .sdo_one_o(serial_out_one), .sdo_two_o(serial_out_two), .uart_o(uart), .pwm_o(pwm),
        .cin_one_o(cin1), .cin_two_o(cin2), .refclk_o(refclk));
    signal_modulator i_signal_modulator (.mclk_i(mclk), .rst_b_i(rst_b),
        .sys_reset_i(sys_reset), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .modulation_input_pin_i(min_pin), .serial_out_one_i(serial_out_one),
        .serial_out_two_i(serial_out_two), .uart_tx_i(uart), .pwm_out_i(pwm),
        .carrier_input_pin_one_i(cin1), .carrier_input_pin_two_i(cin2),
        .reference_clock_output_i(refclk), .modulated_output_pin_o(mod_out),
        .source_pin_off_o(src_off), .high_pin_off_o(hi_off), .low_pin_off_o(lo_off));

    initial forever #20 mclk = ~mclk;

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    // strobes drop one edge early so back-to-back calls never drive twice
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        check(rdata, exp);
        @(posedge mclk);
    endtask
    task automatic out_check(input logic exp);
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check({15'h0, mod_out}, {15'h0, exp});
        @(posedge mclk);
    endtask
    task automatic por();
        rst_b <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
    endtask

    initial begin
        por();
        rd_check(ADDR_CONTROL, CTL_POR);
        rd_check(ADDR_SOURCE, {8'h00, SRC_DIS_POR, 3'h0, SRC_SEL_POR});
        rd_check(ADDR_CARRIER, CAR_POR);
        wr_reg(4'h3, 16'hffff);
        rd_check(4'h3, 16'h0000);
        for (c = 0; c < 3; c++) begin
            wr_reg(c[3:0], 16'hffff);
            rd_check(c[3:0], mask_t[c]);
        end
        lines <= '0;
        wr_reg(ADDR_SOURCE, 16'h0000);
        for (c = 0; c < 5; c++) begin
            wr_reg(ADDR_CARRIER, car_t[c]);
            wr_reg(ADDR_CONTROL, ctl_t[c]);
            out_check(exp_t[c]);
        end
        wr_reg(ADDR_CONTROL, 16'h8010);
        wr_reg(ADDR_SOURCE, 16'h0085);
        wr_reg(ADDR_CARRIER, 16'h8386);
        out_check(1'b1);
        @(negedge mclk);
        check(src_off, 16'h0020);
        check(hi_off, 16'h0008);
        check(lo_off, 16'h0040);
        @(posedge mclk);
        sys_reset <= 1'b1;
        @(posedge mclk);
        sys_reset <= 1'b0;
        out_check(1'b0);
        rd_check(ADDR_SOURCE, 16'h0085);
        rd_check(ADDR_CARRIER, 16'h0000);
        @(negedge mclk);
        check(src_off, 16'h0020);
        @(posedge mclk);
        por();
        rd_check(ADDR_SOURCE, {8'h00, SRC_DIS_POR, 3'h0, SRC_SEL_POR});
        wr_reg(ADDR_CARRIER, 16'h4000);
        for (c = 0; c < 16; c++) begin
            for (v = 0; v < 2; v++) begin
                onehot = (c >= 1 && c <= 14) ? 17'h1 << (c - 1) : '0;
                lines <= (v == 1) ? onehot : ~onehot;
                wr_reg(ADDR_SOURCE, 16'(c));
                wr_reg(ADDR_CONTROL, 16'h8000 | 16'((c == 0) ? v : 1 - v));
                out_check((c <= 14) && (v == 1));
            end
        end
        wr_reg(ADDR_SOURCE, 16'h0000);
        for (h = 0; h < 2; h++) begin
            for (c = 0; c < 16; c++) begin
                for (v = 0; v < 2; v++) begin
                    onehot = (c >= 1 && c <= 10) ? 17'h1 << ((c < 4) ? c + 13 : c + 3) : '0;
                    lines <= (v == 1) ? onehot : ~onehot;
                    wr_reg(ADDR_CARRIER, 16'((h == 1) ? c << 8 : c));
                    wr_reg(ADDR_CONTROL, 16'h8000 | 16'(h));
                    out_check((c >= 1) && (c <= 10) && (v == 1));
                end
            end
        end
        for (c = 0; c < 2; c++) begin
            lines <= 17'h04000;
            wr_reg(ADDR_CARRIER, sync_t[c]);
            wr_reg(ADDR_CONTROL, 16'h8000 | 16'(1 - c));
            out_check(1'b1);
            wr_reg(ADDR_CONTROL, 16'h8000 | 16'(c));
            out_check(1'b1);
            lines <= 17'h08000;
            out_check(1'b1);
        end
        results();
    end
endmodule
